// *** core/hdlc_packet_tx_rx_fifo.sv ***
// HDLC packet transmitter and receiver with byte FIFOs behind an Avalon-MM slave.
`timescale 1ns/1ps
`include "hdlc_map.svh"
// How it works
// - Underrun sends one abort, flags, holds FIFO.
// - Any write to status clears underrun.
// - Overflow flags event, drops only current packet.
// - Overflow on sending packet aborts and flushes.
// - Overflow pin holds until next data write.
// - Full event latches; live full bit shown.
// - Low-fill event latches; live below bit shown.
// - Flags follow the last sent packet.
// - Complete marked packet starts transmission.
// - Depth above upper threshold starts transmission.
// - Frame check appended when enabled.
// - Not full means one more byte fits.
// - Enabled receiver hunts flags from idle.
// - First flag pushes link-up dummy byte.
// - Abort pushes link-down dummy, sets change.
// - Good end sets packet bit; read clears.
// - Each received byte carries three-bit tag.
// - Fill over threshold interrupts until empty.
// - Receive overrun resets FIFO pointers.
// - Pending bit works with output disabled.
// - Enabled idle transmitter sends flags.
// - Threshold send runs to packet end.
module hdlc_packet_tx_rx_fifo
  import hdlc_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic tx_bit_en,
  output logic tx_bit,
  input wire logic rx_bit_en,
  input wire logic rx_bit,
  output logic overflow_flag,
  output logic irq_out_n
);
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] PONE = {{(AW - 1){1'b0}}, 1'b1};

  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = (c >> 1) ^ ((c[0] ^ b) ? `CRC_POLY : 16'h0000);
  endfunction

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = crc_bit(r, d[i]);
    end
    crc_byte = r;
  endfunction

  // ****************************************
  // Bus slave
  // ****************************************
  // One wait cycle on every access gives the read mux a register stage.
  logic ack_q, wr_acc, rd_acc;
  logic [31:0] readdata_q, rd_mux;
  assign waitrequest = (read | write) & ~ack_q;
  assign wr_acc = write & ack_q;
  assign rd_acc = read & ack_q & ~write;
  assign readdata = readdata_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read | write) & ~ack_q;
    end
  end

  logic tx_en_q, fcs_en_q, tx_clr_q, rx_en_q, irq_oe_q;
  logic [3:0] ien_q;
  logic [6:0] upth_q, loth_q, rxth_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_en_q <= 1'b0;
      fcs_en_q <= 1'b0;
      tx_clr_q <= 1'b0;
      ien_q <= 4'h0;
      upth_q <= `UPTH_RST;
      loth_q <= `LOTH_RST;
      rx_en_q <= 1'b0;
      irq_oe_q <= 1'b0;
      rxth_q <= `RXTH_RST;
    end else if (wr_acc) begin
      unique case (address)
        `TX_CFG_OFF: begin
          tx_en_q <= writedata[`TXCFG_EN_BIT];
          fcs_en_q <= writedata[`TXCFG_FCS_BIT];
          tx_clr_q <= writedata[`TXCFG_CLR_BIT];
        end
        `TX_IEN_OFF: ien_q <= writedata[3:0];
        `TX_UPTH_OFF: upth_q <= writedata[6:0];
        `TX_LOTH_OFF: loth_q <= writedata[6:0];
        `RX_CFG_OFF: rx_en_q <= writedata[`RXCFG_EN_BIT];
        `RX_ICTL_OFF: begin
          irq_oe_q <= writedata[`RXICTL_IE_BIT];
          rxth_q <= writedata[6:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************
  // Transmit FIFO
  // ****************************************
  logic [7:0] txm [DEPTH];
  logic [DEPTH-1:0] txe_q;
  logic [AW-1:0] tw_q, tr_q, tr_nx, pkt_start_q, rw_dist;
  logic [AW:0] tcnt_q, teop_q, rw_cnt;
  logic flush_hold_q, abort_req_q, tx_full, tx_hold, tx_wr_data, tx_push, tx_ovf, tx_flush;
  logic tx_mark, tx_pop, tx_stat_rd, tx_stat_wr, udr_now;
  tx_state_t ts_q;
  tx_events_t tev_q;

  assign tx_full = tcnt_q == FULL_CNT;
  assign tx_hold = tev_q.udr | tx_clr_q;
  assign tx_wr_data = wr_acc && address == `TX_DATA_OFF;
  assign tx_stat_rd = rd_acc && address == `TX_STAT_OFF;
  assign tx_stat_wr = wr_acc && address == `TX_STAT_OFF;
  assign tx_push = tx_wr_data & ~tx_hold & (flush_hold_q | ~tx_full);
  assign tx_ovf = tx_wr_data & ~tx_hold & ~flush_hold_q & tx_full;
  assign tx_flush = tx_ovf && teop_q == '0 && ts_q == TS_DATA;
  assign tx_mark = wr_acc && address == `TX_CFG_OFF && writedata[`TXCFG_EOP_BIT] && !tx_hold
    && tcnt_q != '0 && !txe_q[tw_q - PONE] && !(tx_pop && tcnt_q == (AW + 1)'(1));
  assign tr_nx = tr_q + {{(AW - 1){1'b0}}, tx_pop};
  assign rw_dist = pkt_start_q - tr_nx;
  assign rw_cnt = (rw_dist == '0 && teop_q != '0) ? FULL_CNT : {1'b0, rw_dist};

  always_ff @(posedge clk) begin
    if (tx_push) begin
      txm[tw_q] <= writedata[7:0];
    end
  end

  // Underrun and the clear bit keep the pointers cleared until released; a flush clears them once.
  always_ff @(posedge clk) begin
    if (sys_rst || tx_hold || tx_flush) begin
      tw_q <= '0;
      tr_q <= '0;
      tcnt_q <= '0;
      teop_q <= '0;
      pkt_start_q <= '0;
      txe_q <= '0;
    end else begin
      tr_q <= tr_nx;
      if (tx_ovf) begin
        tw_q <= pkt_start_q;
        tcnt_q <= rw_cnt;
      end else begin
        tw_q <= tw_q + {{(AW - 1){1'b0}}, tx_push};
        tcnt_q <= tcnt_q + {{AW{1'b0}}, tx_push} - {{AW{1'b0}}, tx_pop};
      end
      if (tx_pop) begin
        txe_q[tr_q] <= 1'b0;
      end
      if (tx_push) begin
        txe_q[tw_q] <= 1'b0;
      end
      if (tx_mark) begin
        txe_q[tw_q - PONE] <= 1'b1;
        pkt_start_q <= tw_q;
      end
      teop_q <= teop_q + {{AW{1'b0}}, tx_mark} - {{AW{1'b0}}, tx_pop & txe_q[tr_q]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flush_hold_q <= 1'b0;
    end else begin
      flush_hold_q <= tx_flush | (flush_hold_q & ~tx_wr_data);
    end
  end

  // ****************************************
  // Transmit engine
  // ****************************************
  logic [7:0] tsh_q, tsh_d, tfcs_hi_q;
  logic [2:0] tbit_q, tones_q;
  logic [15:0] tcrc_q, tcrc_nx;
  logic tlast_q, fcs_hi_q, fcs_hi_d, tx_bit_q, tx_stuff, tx_bnd, tx_go, stuffable;
  tx_state_t ts_d;

  assign stuffable = ts_q == TS_DATA || ts_q == TS_FCS;
  assign tx_stuff = stuffable && tones_q == 3'd5;
  assign tx_bnd = tx_en_q && tx_bit_en && !tx_stuff && tbit_q == 3'd0;
  assign tx_go = teop_q != '0 || tcnt_q > (AW + 1)'(upth_q);
  assign tcrc_nx = (ts_q == TS_DATA) ? crc_bit(tcrc_q, tsh_q[0]) : tcrc_q;
  assign tx_bit = tx_bit_q;

  always_comb begin
    ts_d = TS_FLAG;
    tsh_d = `FLAG_BYTE;
    tx_pop = 1'b0;
    udr_now = 1'b0;
    fcs_hi_d = 1'b0;
    if (tx_bnd) begin
      if (abort_req_q) begin
        ts_d = TS_ABORT;
        tsh_d = `ABORT_BYTE;
      end else begin
        unique case (ts_q)
          TS_FLAG, TS_ABORT: begin
            if (tx_go && tcnt_q != '0) begin
              tx_pop = 1'b1;
              ts_d = TS_DATA;
              tsh_d = txm[tr_q];
            end
          end
          TS_DATA: begin
            if (tlast_q) begin
              if (fcs_en_q) begin
                ts_d = TS_FCS;
                tsh_d = ~tcrc_nx[7:0];
                fcs_hi_d = 1'b1;
              end
            end else if (tcnt_q != '0) begin
              tx_pop = 1'b1;
              ts_d = TS_DATA;
              tsh_d = txm[tr_q];
            end else begin
              udr_now = 1'b1;
              ts_d = TS_ABORT;
              tsh_d = `ABORT_BYTE;
            end
          end
          TS_FCS: begin
            if (fcs_hi_q) begin
              ts_d = TS_FCS;
              tsh_d = tfcs_hi_q;
            end
          end
        endcase
      end
    end
  end

  // Bytes leave LSB first; stuffed zeros neither shift nor enter the check sum.
  always_ff @(posedge clk) begin
    if (sys_rst || !tx_en_q) begin
      ts_q <= TS_FLAG;
      tsh_q <= `FLAG_BYTE;
      tbit_q <= 3'd7;
      tones_q <= 3'd0;
      tx_bit_q <= 1'b1;
      tlast_q <= 1'b0;
      tcrc_q <= `CRC_INIT;
      fcs_hi_q <= 1'b0;
      tfcs_hi_q <= 8'h00;
    end else if (tx_bit_en) begin
      if (tx_stuff) begin
        tx_bit_q <= 1'b0;
        tones_q <= 3'd0;
      end else begin
        tx_bit_q <= tsh_q[0];
        tones_q <= (tsh_q[0] && stuffable) ? tones_q + 3'd1 : 3'd0;
        tcrc_q <= (tx_bnd && tx_pop && ts_q != TS_DATA) ? `CRC_INIT : tcrc_nx;
        if (tbit_q == 3'd0) begin
          ts_q <= ts_d;
          tsh_q <= tsh_d;
          tbit_q <= 3'd7;
          fcs_hi_q <= fcs_hi_d;
          if (fcs_hi_d) begin
            tfcs_hi_q <= ~tcrc_nx[15:8];
          end
          if (tx_pop) begin
            tlast_q <= txe_q[tr_q];
          end
        end else begin
          tsh_q <= tsh_q >> 1;
          tbit_q <= tbit_q - 3'd1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      abort_req_q <= 1'b0;
    end else begin
      abort_req_q <= tx_flush | (abort_req_q & ~tx_bnd);
    end
  end

  // ****************************************
  // Transmit events
  // ****************************************
  logic full_prev_q, low_prev_q, below_low, ovf_pin_q;
  assign below_low = tcnt_q < (AW + 1)'(loth_q);
  assign overflow_flag = ovf_pin_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      full_prev_q <= 1'b0;
      low_prev_q <= 1'b1;
      tev_q <= '0;
      ovf_pin_q <= 1'b0;
    end else begin
      full_prev_q <= tx_full;
      low_prev_q <= below_low;
      tev_q.full <= (tx_full & ~full_prev_q) | (tev_q.full & ~tx_stat_rd);
      tev_q.low <= (below_low & ~low_prev_q) | (tev_q.low & ~tx_stat_rd);
      tev_q.ovf <= tx_ovf | (tev_q.ovf & ~tx_stat_rd);
      tev_q.udr <= udr_now | (tev_q.udr & ~tx_stat_wr);
      ovf_pin_q <= tx_ovf | (ovf_pin_q & ~tx_wr_data);
    end
  end

  // ****************************************
  // Receive engine
  // ****************************************
  rx_state_t rs_q;
  logic [2:0] rones_q, rbits_q;
  logic [1:0] pv_q;
  logic [7:0] racc_q, p0_q, p1_q, p2_q, rbyte;
  logic [15:0] rcrc_q;
  logic r_abort, r_flag, r_stuff, r_data, r_done, rx_push, pkt_set, chg_set;
  rx_entry_t rx_ent;

  assign r_abort = rx_bit && rones_q == 3'd6;
  assign r_flag = !rx_bit && rones_q == 3'd6;
  assign r_stuff = !rx_bit && rones_q == 3'd5;
  assign r_data = !r_abort && !r_flag && !r_stuff && rs_q != RS_HUNT && !(rx_bit && rones_q == 3'd7);
  assign r_done = r_data && rbits_q == 3'd7;
  assign rbyte = {rx_bit, racc_q[7:1]};

  always_comb begin
    rx_push = 1'b0;
    pkt_set = 1'b0;
    rx_ent = '{tag: `TAG_DATA, data: p2_q};
    if (rx_en_q && rx_bit_en) begin
      if (r_abort && rs_q != RS_HUNT) begin
        rx_push = 1'b1;
        rx_ent = '{tag: `TAG_DOWN, data: 8'h00};
      end else if (r_flag && rs_q == RS_HUNT) begin
        rx_push = 1'b1;
        rx_ent = '{tag: `TAG_UP, data: 8'h00};
      end else if (r_flag && rs_q == RS_FRAME && pv_q == 2'd3) begin
        rx_push = 1'b1;
        pkt_set = 1'b1;
        rx_ent = '{tag: {1'b1, rcrc_q != `CRC_GOOD, rbits_q != 3'd7}, data: p2_q};
      end else if (r_done && pv_q == 2'd3) begin
        rx_push = 1'b1;
      end
    end
  end
  assign chg_set = rx_push && (rx_ent.tag == `TAG_UP || rx_ent.tag == `TAG_DOWN);

  // The last two bytes of a frame are its check sum, so bytes wait three deep.
  always_ff @(posedge clk) begin
    if (sys_rst || !rx_en_q) begin
      rs_q <= RS_HUNT;
      rones_q <= 3'd7;
      rbits_q <= 3'd0;
      pv_q <= 2'd0;
      racc_q <= 8'h00;
      rcrc_q <= `CRC_INIT;
      p0_q <= 8'h00;
      p1_q <= 8'h00;
      p2_q <= 8'h00;
    end else if (rx_bit_en) begin
      rones_q <= rx_bit ? ((rones_q == 3'd7) ? 3'd7 : rones_q + 3'd1) : 3'd0;
      if (r_abort && rs_q != RS_HUNT) begin
        rs_q <= RS_HUNT;
        pv_q <= 2'd0;
      end else if (r_flag) begin
        rs_q <= RS_LINK;
        pv_q <= 2'd0;
        rbits_q <= 3'd0;
        rcrc_q <= `CRC_INIT;
      end else if (r_data) begin
        rs_q <= RS_FRAME;
        racc_q <= rbyte;
        rbits_q <= rbits_q + 3'd1;
        if (r_done) begin
          rcrc_q <= crc_byte(rcrc_q, rbyte);
          p0_q <= rbyte;
          p1_q <= p0_q;
          p2_q <= p1_q;
          if (pv_q != 2'd3) begin
            pv_q <= pv_q + 2'd1;
          end
        end
      end
    end
  end

  // ****************************************
  // Receive FIFO and status
  // ****************************************
  rx_entry_t rxm [DEPTH];
  logic [AW-1:0] rw_q, rr_q;
  logic [AW:0] rcnt_q;
  logic rx_full, rx_orun, rx_pop, rx_stat_rd, pkt_q, chg_q, orun_q, fill_q, irq_pending;
  logic [2:0] last_tag_q;

  assign rx_full = rcnt_q == FULL_CNT;
  assign rx_orun = rx_push & rx_full;
  assign rx_pop = rd_acc && address == `RX_DATA_OFF && rcnt_q != '0;
  assign rx_stat_rd = rd_acc && address == `RX_STAT_OFF;
  assign irq_pending = pkt_q | chg_q | orun_q | fill_q;

  always_ff @(posedge clk) begin
    if (rx_push && !rx_full) begin
      rxm[rw_q] <= rx_ent;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || rx_orun) begin
      rw_q <= '0;
      rr_q <= '0;
      rcnt_q <= '0;
    end else begin
      rw_q <= rw_q + {{(AW - 1){1'b0}}, rx_push};
      rr_q <= rr_q + {{(AW - 1){1'b0}}, rx_pop};
      rcnt_q <= rcnt_q + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pkt_q <= 1'b0;
      chg_q <= 1'b0;
      orun_q <= 1'b0;
      fill_q <= 1'b0;
      last_tag_q <= `TAG_DATA;
    end else begin
      pkt_q <= pkt_set | (pkt_q & ~rx_stat_rd);
      chg_q <= chg_set | (chg_q & ~rx_stat_rd);
      orun_q <= rx_orun | (orun_q & ~rx_stat_rd);
      fill_q <= (rcnt_q > (AW + 1)'(rxth_q)) | (fill_q & rcnt_q != '0);
      if (rx_pop) begin
        last_tag_q <= rxm[rr_q].tag;
      end
    end
  end

  // ****************************************
  // Interrupt and read data
  // ****************************************
  assign irq_out_n = ~((|(tev_q & ien_q)) | (irq_oe_q & irq_pending));

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (address)
      `TX_CFG_OFF: rd_mux[3:0] = {tx_clr_q, 1'b0, fcs_en_q, tx_en_q};
      `TX_IEN_OFF: rd_mux[3:0] = ien_q;
      `TX_STAT_OFF: rd_mux[5:0] = {below_low, tx_full, tev_q};
      `TX_UPTH_OFF: rd_mux[6:0] = upth_q;
      `TX_LOTH_OFF: rd_mux[6:0] = loth_q;
      `RX_CFG_OFF: rd_mux[0] = rx_en_q;
      `RX_ICTL_OFF: rd_mux[7:0] = {irq_oe_q, rxth_q};
      `RX_STAT_OFF: rd_mux[7:0] = {last_tag_q, rcnt_q == '0, orun_q, pkt_q, chg_q,
        irq_pending};
      `RX_DATA_OFF: rd_mux[10:0] = (rcnt_q != '0) ? rxm[rr_q] : 11'h000;
      default: ;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata_q <= rd_mux;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  udr_abort_a: assert property ($rose(tev_q.udr) |-> ts_q == TS_ABORT && tcnt_q == '0)
    else $error("underrun without abort");
  udr_clear_a: assert property (tev_q.udr && tx_stat_wr |=> !tev_q.udr && tcnt_q == '0)
    else $error("underrun not cleared");
  ovf_flush_a: assert property (tx_flush |=> tcnt_q == '0 && flush_hold_q ##0 abort_req_q)
    else $error("overflow flush missing");
  ovf_pin_a: assert property (tx_ovf ##1 !tx_wr_data [*2] |=> overflow_flag)
    else $error("overflow pin dropped early");
  full_latch_a: assert property ($fell(tx_full) && $past(tev_q.full) && !$past(tx_stat_rd)
    |-> tev_q.full)
    else $error("full event lost");
  push_room_a: assert property (tx_push && !tx_pop |=> tcnt_q == $past(tcnt_q) + 1)
    else $error("byte not stored");
  idle_flag_a: assert property (tx_bnd && ts_q == TS_FLAG && tcnt_q == '0 && !abort_req_q
    |=> tsh_q == `FLAG_BYTE && ts_q == TS_FLAG)
    else $error("no idle flag");
  link_up_a: assert property (rx_en_q && rx_bit_en && r_flag && rs_q == RS_HUNT
    |=> chg_q && rs_q == RS_LINK && rcnt_q != '0)
    else $error("link up not reported");
  pkt_clear_a: assert property (rx_stat_rd && !pkt_set |=> !pkt_q)
    else $error("packet bit not cleared");
  rx_orun_a: assert property (rx_orun |=> rcnt_q == '0 && orun_q)
    else $error("overrun not handled");
  fill_hold_a: assert property (fill_q && rcnt_q != '0 |=> fill_q)
    else $error("fill interrupt dropped");

  pkt_done_c: cover property (pkt_set ##1 pkt_q);
  tx_fcs_c: cover property (ts_q == TS_DATA ##[1:300] ts_q == TS_FCS);
  tx_udr_c: cover property ($rose(tev_q.udr));
  rx_down_c: cover property (chg_set && rx_ent.tag == `TAG_DOWN);
endmodule

// *** core/hdlc_map.svh ***
// Register offsets, field positions, reset values and line codes of the HDLC packet block.
`ifndef HDLC_MAP_SVH
`define HDLC_MAP_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define TX_CFG_OFF 8'h00
`define TX_IEN_OFF 8'h04
`define TX_STAT_OFF 8'h08
`define TX_DATA_OFF 8'h0C
`define TX_UPTH_OFF 8'h10
`define TX_LOTH_OFF 8'h14
`define RX_CFG_OFF 8'h18
`define RX_ICTL_OFF 8'h1C
`define RX_STAT_OFF 8'h20
`define RX_DATA_OFF 8'h24

// ****************************************
// Field positions
// ****************************************
`define TXCFG_EN_BIT 0
`define TXCFG_FCS_BIT 1
`define TXCFG_EOP_BIT 2
`define TXCFG_CLR_BIT 3
`define TXST_FULLNOW_BIT 4
`define TXST_BLOW_BIT 5
`define RXCFG_EN_BIT 0
`define RXICTL_IE_BIT 7
`define RXST_IRQ_BIT 0
`define RXST_LINKCHG_BIT 1
`define RXST_PKT_BIT 2
`define RXST_ORUN_BIT 3
`define RXST_EMPTY_BIT 4
`define RXST_TAG_LSB 5

// ****************************************
// Reset values
// ****************************************
`define UPTH_RST 7'h40
`define LOTH_RST 7'h10
`define RXTH_RST 7'h40

// ****************************************
// Line codes
// ****************************************
`define FLAG_BYTE 8'h7E
`define ABORT_BYTE 8'hFF
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h8408
`define CRC_GOOD 16'hF0B8
`define TAG_DATA 3'h0
`define TAG_UP 3'h1
`define TAG_DOWN 3'h2

`endif

// *** core/hdlc_pkg.sv ***
// Types shared by the HDLC packet block.
package hdlc_pkg;
  typedef enum logic [3:0] {
    TS_FLAG = 4'h1,
    TS_DATA = 4'h2,
    TS_FCS = 4'h4,
    TS_ABORT = 4'h8
  } tx_state_t;

  typedef enum logic [2:0] {
    RS_HUNT = 3'h1,
    RS_LINK = 3'h2,
    RS_FRAME = 3'h4
  } rx_state_t;

  typedef struct packed {
    logic [2:0] tag;
    logic [7:0] data;
  } rx_entry_t;

  typedef struct packed {
    logic udr;
    logic ovf;
    logic low;
    logic full;
  } tx_events_t;
endpackage

// *** testbench/hdlc_link_partner.sv ***
// Data-link slot model that paces both bit streams and records the bits sent.
`timescale 1ns/1ps
module hdlc_link_partner (
  input wire logic clk,
  input wire logic slow,
  input wire logic tx_bit,
  output logic tx_bit_en,
  output logic rx_bit_en,
  output logic rx_bit,
  output logic [7:0] tx_seen,
  output logic rx_idle
);
  logic [2:0] div_q;
  logic bits_q[$];
  logic slot;

  // With slow set, a sparse slot every eighth cycle (every fourth otherwise) shows the block coping with a slow link.
  assign slot = (div_q[1:0] == 2'h3) && (!slow || div_q[2]);

  initial begin
    div_q = 3'h0;
    tx_bit_en = 1'b0;
    rx_bit_en = 1'b0;
    rx_bit = 1'b1;
    tx_seen = 8'h00;
    rx_idle = 1'b1;
  end

  task automatic send_byte(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      bits_q.push_back(b[i]);
    end
  endtask

  always @(posedge clk) begin
    div_q <= div_q + 3'h1;
    tx_bit_en <= slot;
    rx_bit_en <= slot;
    rx_idle <= (bits_q.size() == 0);
    if (tx_bit_en) begin
      tx_seen <= {tx_bit, tx_seen[7:1]};
    end
    if (slot) begin
      // With no bits queued the line idles at all ones.
      rx_bit <= (bits_q.size() != 0) ? bits_q.pop_front() : 1'b1;
    end
  end
endmodule

// *** testbench/hdlc_packet_tx_rx_fifo_bench.sv ***
// Self-checking bench for the HDLC packet block and its link partner.
`timescale 1ns/1ps
`include "hdlc_map.svh"
module hdlc_packet_tx_rx_fifo_bench;
  logic clk, sys_rst, read, write, waitrequest, overflow_flag, irq_out_n;
  logic tx_bit_en, tx_bit, rx_bit_en, rx_bit, slow, rx_idle;
  logic [7:0] address, tx_seen;
  logic [31:0] writedata, readdata;
  logic [63:0] note_q[$];
  logic [63:0] note;
  int err_count, n_checks, cyc, seed;

  hdlc_packet_tx_rx_fifo #(.DEPTH(128), .AW(7)) dut (.clk(clk), .sys_rst(sys_rst),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .tx_bit_en(tx_bit_en),
    .tx_bit(tx_bit), .rx_bit_en(rx_bit_en), .rx_bit(rx_bit),
    .overflow_flag(overflow_flag), .irq_out_n(irq_out_n));

  hdlc_link_partner lnk (.clk(clk), .slow(slow), .tx_bit(tx_bit), .tx_bit_en(tx_bit_en),
    .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .tx_seen(tx_seen), .rx_idle(rx_idle));

  // ********
  // Clock and helpers
  // ********
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("Checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // The request is dropped for one cycle after acceptance, so accesses never merge.
  task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
    address <= a;
    read <= rd;
    write <= !rd;
    writedata <= d;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
    note_q.push_back({msk, exp});
    bus(1'b1, a, 32'h0);
  endtask

  task automatic wait_tx(input logic [7:0] b);
    for (int n = 0; n < 800 && tx_seen !== b; n++) begin
      @(posedge clk);
    end
  endtask

  // The idle flag lags the last queued bit by one cycle, so two edges pass first.
  task automatic wait_rx();
    repeat (2) @(posedge clk);
    for (int n = 0; n < 800 && rx_idle !== 1'b1; n++) begin
      @(posedge clk);
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (read && waitrequest === 1'b0) begin
      note = note_q.pop_front();
      check("readdata", readdata & note[63:32], note[31:0]);
    end
    if (cyc > 40000) begin
      err_count++;
      stop_test();
    end
  end

  // ********
  // Stimulus
  // ********
  initial begin
    seed = 2;
    sys_rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0;
    slow = 1'b0;
    err_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(`TX_UPTH_OFF, 32'h40, 32'h7F);
    rd(`TX_LOTH_OFF, 32'h10, 32'h7F);
    rd(`RX_ICTL_OFF, 32'h40, 32'hFF);
    rd(8'h30, 32'h0, 32'hFFFFFFFF);
    // Fill past full with the transmitter off, so nothing drains meanwhile.
    for (int i = 0; i < 129; i++) begin
      if (i == 127) begin
        rd(`TX_STAT_OFF, 32'h00, 32'h10);
      end
      wr(`TX_DATA_OFF, {24'h0, 8'($random(seed))});
    end
    check("overflow_flag", {31'h0, overflow_flag}, 32'h1);
    check("irq_out_n", {31'h0, irq_out_n}, 32'h1);
    wr(`TX_IEN_OFF, 32'h4);
    check("irq_out_n", {31'h0, irq_out_n}, 32'h0);
    rd(`TX_STAT_OFF, 32'h05, 32'h15);
    check("irq_out_n", {31'h0, irq_out_n}, 32'h1);
    wr(`TX_DATA_OFF, 32'h0);
    check("overflow_flag", {31'h0, overflow_flag}, 32'h0);
    wr(`TX_CFG_OFF, 32'h8);
    wr(`TX_CFG_OFF, 32'h1);
    wait_tx(8'h7E);
    check("tx_seen", {24'h0, tx_seen}, 32'h7E);
    wr(`TX_DATA_OFF, 32'h0);
    wr(`TX_CFG_OFF, 32'h5);
    wait_tx(8'h00);
    check("tx_seen", {24'h0, tx_seen}, 32'h00);
    wait_tx(8'h7E);
    check("tx_seen", {24'h0, tx_seen}, 32'h7E);
    // A single zero byte carries the check sum 78h then F0h, low byte first.
    wr(`TX_DATA_OFF, 32'h0);
    wr(`TX_CFG_OFF, 32'h7);
    wait_tx(8'h78);
    check("tx_seen", {24'h0, tx_seen}, 32'h78);
    wait_tx(8'hF0);
    check("tx_seen", {24'h0, tx_seen}, 32'hF0);
    wr(`TX_UPTH_OFF, 32'h1);
    wr(`TX_DATA_OFF, 32'h0);
    wr(`TX_DATA_OFF, 32'h0);
    wait_tx(8'hFF);
    check("tx_seen", {24'h0, tx_seen}, 32'hFF);
    rd(`TX_STAT_OFF, 32'h08, 32'h08);
    wr(`TX_STAT_OFF, 32'h0);
    rd(`TX_STAT_OFF, 32'h00, 32'h08);
    slow <= 1'b1;
    wr(`RX_CFG_OFF, 32'h1);
    lnk.send_byte(8'h7E);
    lnk.send_byte(8'hFF);
    wait_rx();
    rd(`RX_DATA_OFF, 32'h100, 32'h700);
    rd(`RX_DATA_OFF, 32'h200, 32'h700);
    rd(`RX_STAT_OFF, 32'h12, 32'h12);
    // One good frame: a zero byte and its check sum, closed by a flag, then an abort.
    wr(`RX_ICTL_OFF, 32'hC0);
    lnk.send_byte(8'h7E);
    lnk.send_byte(8'h00);
    lnk.send_byte(8'h78);
    lnk.send_byte(8'hF0);
    lnk.send_byte(8'h7E);
    lnk.send_byte(8'hFF);
    wait_rx();
    check("irq_out_n", {31'h0, irq_out_n}, 32'h0);
    rd(`RX_DATA_OFF, 32'h100, 32'h7FF);
    rd(`RX_DATA_OFF, 32'h400, 32'h7FF);
    rd(`RX_STAT_OFF, 32'h87, 32'hFF);
    rd(`RX_DATA_OFF, 32'h200, 32'h7FF);
    rd(`RX_STAT_OFF, 32'h50, 32'hFF);
    check("irq_out_n", {31'h0, irq_out_n}, 32'h1);
    stop_test();
  end
endmodule
